// ### rhc_pkg.sv
package rhc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register map, byte offsets inside the clock block window
   localparam logic [4:0] RHC_ADDR_CTRL1   = 5'h00;
   localparam logic [4:0] RHC_ADDR_HOUR    = 5'h02;
   localparam logic [4:0] RHC_ADDR_FRT_HI  = 5'h10;
   localparam logic [4:0] RHC_ADDR_FRT_LO  = 5'h11;
   localparam logic [7:0] RHC_UNMAPPED_RD  = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // hour register fields
   localparam int         RHC_HOUR_BUSY_BIT = 7;
   localparam int         RHC_HOUR_RSVD_BIT = 6;
   localparam int         RHC_TENS_MSB      = 5;
   localparam int         RHC_TENS_LSB      = 4;
   localparam int         RHC_ONES_MSB      = 3;
   localparam int         RHC_ONES_LSB      = 0;
   localparam logic [5:0] RHC_HOUR_CLEAR    = 6'h00;
   localparam logic [5:0] RHC_HOUR_MAX_12   = 6'h11;
   localparam logic [5:0] RHC_HOUR_MAX_24   = 6'h23;
   localparam logic [3:0] RHC_ONES_LAST     = 4'h9;

   ////////////////////////////////////////////////////////////////////////
   // first clock control register fields
   localparam int         RHC_CTRL_SOFTCLR_BIT = 0;
   localparam int         RHC_CTRL_FMT24_BIT   = 1;
   localparam logic [7:0] RHC_CTRL_RESET       = 8'h00;
   localparam logic [7:0] RHC_CTRL_WR_MASK     = 8'h03;

   ////////////////////////////////////////////////////////////////////////
   // free running timer
   localparam logic [15:0] RHC_FRT_RESET = 16'h0000;
   localparam logic [15:0] RHC_FRT_STEP  = 16'h0001;

   typedef enum logic [3:0]
   {
      RHC_MODE_HIGH,
      RHC_MODE_MEDIUM,
      RHC_MODE_SLEEP,
      RHC_MODE_MSTOP,
      RHC_MODE_WATCH,
      RHC_MODE_SUBACT,
      RHC_MODE_SUBSLEEP,
      RHC_MODE_SWSTBY,
      RHC_MODE_HWSTBY
   } rhc_mode_e;

endpackage

// ### rhc_bcd_step.sv
module rhc_bcd_step
   import rhc_pkg::*;
(
   // present hour value and format
   input  wire logic [5:0] hour_now,
   input  wire logic       fmt24,
   // stepped value
   output logic      [5:0] hour_step,
   output logic            wrap
);

   logic [5:0] hour_max;
   logic [3:0] ones_now;
   logic [1:0] tens_now;

   always_comb
   begin
      ones_now  = hour_now[RHC_ONES_MSB:RHC_ONES_LSB];
      tens_now  = hour_now[RHC_TENS_MSB:RHC_TENS_LSB];
      hour_max  = fmt24 ? RHC_HOUR_MAX_24 : RHC_HOUR_MAX_12;
      wrap      = 1'b0;
      // anything at or past the top also wraps, so a bad host write recovers
      if (hour_now >= hour_max)
      begin
         hour_step = RHC_HOUR_CLEAR;
         wrap      = 1'b1;
      end
      else if (ones_now >= RHC_ONES_LAST)
      begin
         hour_step = {2'(tens_now + 2'h1), 4'h0};
      end
      else
      begin
         hour_step = {tens_now, 4'(ones_now + 4'h1)};
      end
   end

endmodule

// ### rhc_bus_port.sv
module rhc_bus_port
   import rhc_pkg::*;
(
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic clk_en,
   // area strobes from host
   input  wire logic bus_cs_n,
   input  wire logic bus_rd_n,
   input  wire logic bus_wr_n,
   // decoded
   output logic      rd_active,
   output logic      wr_stb
);

   logic wr_active;
   logic wr_seen_reg;

   assign rd_active = !bus_cs_n && !bus_rd_n;
   assign wr_active = !bus_cs_n && !bus_wr_n;
   // one store per strobe however long the host stretches it
   assign wr_stb    = wr_active && !wr_seen_reg && clk_en;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         wr_seen_reg <= 1'b0;
      else if (clk_en)
         wr_seen_reg <= wr_active;
   end

endmodule

// ### rhc_hour_counter.sv
module rhc_hour_counter
   import rhc_pkg::*;
(
   // clock, reset, enable
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       clk_en,
   // host external-area bus
   input  wire logic       bus_cs_n,
   input  wire logic       bus_rd_n,
   input  wire logic       bus_wr_n,
   input  wire logic [4:0] bus_addr,
   input  wire logic [7:0] bus_data_in,
   output logic      [7:0] bus_data_out,
   output logic            bus_data_oe,
   // neighbouring stages and power state
   input  wire logic       hour_carry_in,
   input  wire logic       upstream_busy,
   input  wire rhc_mode_e  pwr_mode,
   input  wire logic       standby_pin_n,
   output logic            day_carry_out,
   output logic            update_in_progress
);

   ////////////////////////////////////////////////////////////////////////
   // declarations
   logic [5:0]  hour_reg;
   logic [5:0]  hour_next;
   logic [7:0]  ctrl_reg;
   logic [15:0] frt_reg;
   logic [7:0]  rdata_reg;
   logic [7:0]  rdata_next;
   logic        carry_pend_reg;
   logic        day_carry_reg;
   logic [5:0]  hour_step;
   logic        hour_wrap;
   logic        rd_active;
   logic        wr_stb;
   logic        hw_standby;
   logic        clock_run;
   logic        frt_run;
   logic        soft_clear;
   logic        wr_hour;
   logic        wr_ctrl;
   logic        hour_apply;

   ////////////////////////////////////////////////////////////////////////
   // submodules
   rhc_bus_port u_port
   (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .clk_en    (clk_en),
      .bus_cs_n  (bus_cs_n),
      .bus_rd_n  (bus_rd_n),
      .bus_wr_n  (bus_wr_n),
      .rd_active (rd_active),
      .wr_stb    (wr_stb)
   );

   rhc_bcd_step u_step
   (
      .hour_now  (hour_reg),
      .fmt24     (ctrl_reg[RHC_CTRL_FMT24_BIT]),
      .hour_step (hour_step),
      .wrap      (hour_wrap)
   );

   ////////////////////////////////////////////////////////////////////////
   // power state decode
   assign hw_standby = !standby_pin_n || (pwr_mode == RHC_MODE_HWSTBY);
   assign clock_run  = !hw_standby && (pwr_mode != RHC_MODE_MSTOP);
   assign frt_run    = (pwr_mode == RHC_MODE_HIGH) ||
                       (pwr_mode == RHC_MODE_MEDIUM) ||
                       (pwr_mode == RHC_MODE_SLEEP);
   assign soft_clear = ctrl_reg[RHC_CTRL_SOFTCLR_BIT];
   assign wr_hour    = wr_stb && (bus_addr == RHC_ADDR_HOUR);
   assign wr_ctrl    = wr_stb && (bus_addr == RHC_ADDR_CTRL1);
   // host write beats a pending step so the written value is exact
   assign hour_apply = carry_pend_reg && clock_run && !wr_hour;

   ////////////////////////////////////////////////////////////////////////
   // control register
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         ctrl_reg <= RHC_CTRL_RESET;
      else if (clk_en)
      begin
         if (hw_standby)
            ctrl_reg <= RHC_CTRL_RESET;
         else if (wr_ctrl)
            ctrl_reg <= bus_data_in & RHC_CTRL_WR_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // hourly carry capture; the step lands one cycle later under busy
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         carry_pend_reg <= 1'b0;
      else if (clk_en)
      begin
         if (hw_standby || soft_clear)
            carry_pend_reg <= 1'b0;
         else if (hour_carry_in && clock_run)
            carry_pend_reg <= 1'b1;
         else if (clock_run)
            carry_pend_reg <= 1'b0;
      end
   end

   assign update_in_progress = upstream_busy || carry_pend_reg;

   ////////////////////////////////////////////////////////////////////////
   // hour register: deliberately outside rst_n, keeps time across resets
   always_comb
   begin
      hour_next = hour_reg;
      if (hw_standby || soft_clear)
         hour_next = RHC_HOUR_CLEAR;
      else if (wr_hour)
         hour_next = bus_data_in[RHC_TENS_MSB:RHC_ONES_LSB];
      else if (hour_apply)
         hour_next = hour_step;
   end

   always_ff @(posedge mclk)
   begin
      if (clk_en)
         hour_reg <= hour_next;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         day_carry_reg <= 1'b0;
      else if (clk_en)
         day_carry_reg <= hour_apply && hour_wrap && !hw_standby && !soft_clear;
   end

   assign day_carry_out = day_carry_reg;

   ////////////////////////////////////////////////////////////////////////
   // free running timer
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         frt_reg <= RHC_FRT_RESET;
      else if (clk_en)
      begin
         if (hw_standby)
            frt_reg <= RHC_FRT_RESET;
         else if (frt_run)
            frt_reg <= frt_reg + RHC_FRT_STEP;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read path, sampled every cycle of the strobe so the host sees it by T3
   always_comb
   begin
      rdata_next = RHC_UNMAPPED_RD;
      unique case (bus_addr)
         RHC_ADDR_HOUR:
            rdata_next = {update_in_progress, 1'b0, hour_reg};
         RHC_ADDR_CTRL1:
            rdata_next = ctrl_reg;
         RHC_ADDR_FRT_HI:
            rdata_next = frt_reg[15:8];
         RHC_ADDR_FRT_LO:
            rdata_next = frt_reg[7:0];
         default:
            rdata_next = RHC_UNMAPPED_RD;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         rdata_reg <= RHC_UNMAPPED_RD;
      else if (clk_en && rd_active)
         rdata_reg <= rdata_next;
   end

   assign bus_data_out = rdata_reg;
   assign bus_data_oe  = rd_active;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   hour_step_a: assert property (
      clk_en && carry_pend_reg && clock_run && !wr_hour && !soft_clear
      |=> hour_reg == $past(hour_step))
      else $error("hour did not step on carry");

   hour_clear_a: assert property (
      clk_en && (!standby_pin_n || soft_clear) |=> hour_reg == RHC_HOUR_CLEAR)
      else $error("hour not cleared by standby or soft clear");

   hour_wrap_a: assert property (
      clk_en && hour_apply && !soft_clear &&
      hour_reg == (ctrl_reg[RHC_CTRL_FMT24_BIT] ? RHC_HOUR_MAX_24 : RHC_HOUR_MAX_12)
      |=> hour_reg == RHC_HOUR_CLEAR && day_carry_out)
      else $error("hour did not wrap at top of range");

   range_twelve_a: assert property (
      clk_en && hour_apply && !soft_clear && !ctrl_reg[RHC_CTRL_FMT24_BIT] &&
      hour_reg == 6'h09 |=> hour_reg == 6'h10)
      else $error("12-hour count skipped ten");

   ones_carry_a: assert property (
      clk_en && hour_apply && !soft_clear && hour_reg == 6'h19 &&
      ctrl_reg[RHC_CTRL_FMT24_BIT] |=> hour_reg == 6'h20)
      else $error("ones digit did not carry into tens");

   busy_read_a: assert property (
      clk_en && rd_active && bus_addr == RHC_ADDR_HOUR
      |=> bus_data_out[RHC_HOUR_BUSY_BIT] == $past(update_in_progress))
      else $error("busy bit wrong on read");

   rsvd_zero_a: assert property (
      clk_en && rd_active && bus_addr == RHC_ADDR_HOUR
      |=> !bus_data_out[RHC_HOUR_RSVD_BIT])
      else $error("reserved hour bit read as one");

   mstop_hold_a: assert property (
      clk_en && pwr_mode == RHC_MODE_MSTOP && standby_pin_n && !soft_clear && !wr_hour
      |=> $stable(hour_reg))
      else $error("hour moved in module stop");

   frt_hold_a: assert property (
      clk_en && !frt_run && !hw_standby |=> $stable(frt_reg))
      else $error("free running timer moved while halted");

   frt_reset_a: assert property (
      clk_en && hw_standby |=> frt_reg == RHC_FRT_RESET)
      else $error("free running timer not reset in standby");

   wr_single_a: assert property (
      wr_stb |=> !wr_stb)
      else $error("write strobe longer than one cycle");

   busy_on_carry_a: assert property (
      clk_en && hour_carry_in && clock_run && !soft_clear |=> update_in_progress)
      else $error("busy not raised by hourly carry");

   write_lands_a: assert property (
      clk_en && wr_hour && !hw_standby && !soft_clear
      |=> {2'h0, hour_reg} == ($past(bus_data_in) & 8'h3F))
      else $error("host hour write not stored");

   tens_bound_a: assert property (
      clk_en && hour_apply && !soft_clear && hour_reg < RHC_HOUR_MAX_24
      |=> hour_reg[RHC_TENS_MSB:RHC_TENS_LSB] <= 2'h2)
      else $error("tens digit stepped past two");

   day_pulse_a: assert property (
      clk_en && day_carry_out |=> !day_carry_out)
      else $error("day carry longer than one cycle");

   hwstby_reset_a: assert property (
      clk_en && pwr_mode == RHC_MODE_HWSTBY
      |=> hour_reg == RHC_HOUR_CLEAR && frt_reg == RHC_FRT_RESET)
      else $error("hardware standby did not reset the clock");

   halted_carry_a: assert property (
      clk_en && !clock_run && !carry_pend_reg |=> !carry_pend_reg)
      else $error("carry taken while clock halted");

   frt_count_a: assert property (
      clk_en && frt_run && !hw_standby |=> frt_reg == $past(frt_reg) + RHC_FRT_STEP)
      else $error("free running timer did not advance");

   // a low enable must freeze every stage, not just the counter
   freeze_hold_a: assert property (
      !clk_en |=> $stable(hour_reg) && $stable(frt_reg) && $stable(ctrl_reg))
      else $error("state moved with enable low");

   oe_follow_a: assert property (
      bus_data_oe == (!bus_cs_n && !bus_rd_n))
      else $error("read enable does not follow strobes");

   wrap_c: cover property (hour_apply && hour_wrap ##1 day_carry_out);
   softclr_c: cover property (wr_ctrl && bus_data_in[RHC_CTRL_SOFTCLR_BIT]);
   busy_rd_c: cover property (rd_active && bus_addr == RHC_ADDR_HOUR && update_in_progress);
   mstop_carry_c: cover property (hour_carry_in && pwr_mode == RHC_MODE_MSTOP);
   freeze_c: cover property (!clk_en && hour_carry_in);

endmodule

// ### rhc_host_model.sv
module rhc_host_model
   import rhc_pkg::*;
(
   // clock
   input  wire logic       mclk,
   // external-area strobes and data
   output logic            bus_cs_n,
   output logic            bus_rd_n,
   output logic            bus_wr_n,
   output logic      [4:0] bus_addr,
   output logic      [7:0] bus_data_in,
   input  wire logic [7:0] bus_data_out,
   input  wire logic       bus_data_oe
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      bus_cs_n    = 1'b1;
      bus_rd_n    = 1'b1;
      bus_wr_n    = 1'b1;
      bus_addr    = 5'h00;
      bus_data_in = 8'h5A;
   end

   ////////////////////////////////////////////////////////////
   // four-cycle byte write: select, strobe, hold, release
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus_cs_n    <= 1'b0;
      bus_addr    <= a;
      bus_data_in <= d;
      @(posedge mclk);
      bus_wr_n    <= 1'b0;
      @(posedge mclk);
      @(posedge mclk);
      bus_wr_n    <= 1'b1;
      bus_cs_n    <= 1'b1;
      // released bus must not keep showing the last byte
      bus_data_in <= ~d;
   endtask

   task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic oe);
      @(posedge mclk);
      bus_cs_n <= 1'b0;
      bus_rd_n <= 1'b0;
      bus_addr <= a;
      @(posedge mclk);
      @(posedge mclk);
      // data captured on the first strobe edge still stands here
      oe = bus_data_oe;
      d  = bus_data_out;
      bus_rd_n <= 1'b1;
      bus_cs_n <= 1'b1;
   endtask

   // time values are only trusted from a read taken with busy clear
   task automatic rd_settled(input logic [4:0] a, output logic [7:0] d, output logic oe);
      rd(a, d, oe);
      for (int n = 0; n < 4 && d[RHC_HOUR_BUSY_BIT]; n++)
         rd(a, d, oe);
   endtask
endmodule

// ### tb.sv
module tb
   import rhc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic       mclk          = 1'b0;
   logic       rst_n         = 1'b0;
   logic       clk_en        = 1'b1;
   logic       hour_carry_in = 1'b0;
   logic       upstream_busy = 1'b0;
   logic       standby_pin_n = 1'b0;
   rhc_mode_e  pwr_mode      = RHC_MODE_HIGH;
   logic       bus_cs_n, bus_rd_n, bus_wr_n, bus_data_oe, day_carry_out, update_in_progress, oe;
   logic [4:0] bus_addr;
   logic [7:0] bus_data_in, bus_data_out, rdat, rdat2;
   int         err_total = 0;
   int         cmp_count = 0;
   int         day_cnt   = 0;
   int         cnt0;
   // start hour, carries, expected hour, day carries; last three in 24-hour range
   localparam logic [7:0] CASES [6][4] = '{'{8'h11, 8'h01, 8'h00, 8'h01}, '{8'h10, 8'h01, 8'h11, 8'h00},
      '{8'h08, 8'h02, 8'h10, 8'h00}, '{8'h23, 8'h01, 8'h00, 8'h01}, '{8'h11, 8'h01, 8'h12, 8'h00},
      '{8'h19, 8'h01, 8'h20, 8'h00}};

   always #2 mclk = ~mclk;

   always @(posedge mclk)
      if (day_carry_out === 1'b1)
         day_cnt <= day_cnt + 1;

   rhc_hour_counter i_dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .bus_cs_n(bus_cs_n),
      .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n), .bus_addr(bus_addr), .bus_data_in(bus_data_in),
      .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe), .hour_carry_in(hour_carry_in),
      .upstream_busy(upstream_busy), .pwr_mode(pwr_mode), .standby_pin_n(standby_pin_n),
      .day_carry_out(day_carry_out), .update_in_progress(update_in_progress));

   rhc_host_model i_host (.mclk(mclk), .bus_cs_n(bus_cs_n), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n),
      .bus_addr(bus_addr), .bus_data_in(bus_data_in), .bus_data_out(bus_data_out),
      .bus_data_oe(bus_data_oe));

   ////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp, input string what);
      i_host.rd(a, rdat, oe);
      check("read enable", {7'h00, oe}, 8'h01);
      check(what, rdat, exp);
   endtask

   task automatic carry(input int n);
      repeat (n)
      begin
         @(posedge mclk);
         hour_carry_in <= 1'b1;
      end
      @(posedge mclk);
      hour_carry_in <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      standby_pin_n <= 1'b1;
      rd_chk(RHC_ADDR_HOUR, 8'h00, "hour after standby");
      i_host.wr(RHC_ADDR_HOUR, 8'hE5);
      rd_chk(RHC_ADDR_HOUR, 8'h25, "reserved and busy bits");
      rd_chk(5'h05, RHC_UNMAPPED_RD, "unmapped");
      #1 check("read enable idle", {7'h00, bus_data_oe}, 8'h00);
      for (int m = 0; m <= 8; m++)
      begin
         i_host.wr(RHC_ADDR_HOUR, 8'h05);
         pwr_mode <= rhc_mode_e'(m);
         carry(1);
         pwr_mode <= RHC_MODE_HIGH;
         rd_chk(RHC_ADDR_HOUR, (rhc_mode_e'(m) == RHC_MODE_MSTOP) ? 8'h05 :
            (rhc_mode_e'(m) == RHC_MODE_HWSTBY) ? 8'h00 : 8'h06, "hour per mode");
      end
      i_host.wr(RHC_ADDR_HOUR, 8'h09);
      @(posedge mclk);
      hour_carry_in <= 1'b1;
      @(posedge mclk);
      hour_carry_in <= 1'b0;
      #1 check("busy after carry", {7'h00, update_in_progress}, 8'h01);
      @(posedge mclk);
      #1 check("busy after step", {7'h00, update_in_progress}, 8'h00);
      rd_chk(RHC_ADDR_HOUR, 8'h10, "ones carry into tens");
      clk_en <= 1'b0;
      carry(1);
      clk_en <= 1'b1;
      rd_chk(RHC_ADDR_HOUR, 8'h10, "hour frozen without enable");
      for (int i = 0; i < 6; i++)
      begin
         if (i == 3)
            i_host.wr(RHC_ADDR_CTRL1, 8'h02);
         i_host.wr(RHC_ADDR_HOUR, CASES[i][0]);
         cnt0 = day_cnt;
         carry(CASES[i][1]);
         rd_chk(RHC_ADDR_HOUR, CASES[i][2], "hour after carries");
         check("day carries", 8'(day_cnt - cnt0), CASES[i][3]);
      end
      i_host.wr(RHC_ADDR_HOUR, 8'h07);
      i_host.wr(RHC_ADDR_CTRL1, 8'h03);
      rd_chk(RHC_ADDR_HOUR, 8'h00, "soft clear");
      i_host.wr(RHC_ADDR_CTRL1, 8'h02);
      upstream_busy <= 1'b1;
      rd_chk(RHC_ADDR_HOUR, 8'h80, "busy from other stages");
      fork
         begin
            repeat (2) @(posedge mclk);
            upstream_busy <= 1'b0;
         end
      join_none
      i_host.rd_settled(RHC_ADDR_HOUR, rdat, oe);
      check("settled hour", rdat, 8'h00);
      i_host.wr(RHC_ADDR_HOUR, 8'h21);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      rd_chk(RHC_ADDR_HOUR, 8'h21, "hour through reset");
      // reads are three cycles apart, so a running timer moves by exactly three
      for (int m = 0; m <= 7; m++)
      begin
         @(posedge mclk);
         pwr_mode <= rhc_mode_e'(m);
         i_host.rd(RHC_ADDR_FRT_LO, rdat, oe);
         i_host.rd(RHC_ADDR_FRT_LO, rdat2, oe);
         check("timer step", rdat2 - rdat, (m <= 2) ? 8'h03 : 8'h00);
      end
      @(posedge mclk);
      pwr_mode <= RHC_MODE_HWSTBY;
      repeat (2) @(posedge mclk);
      pwr_mode <= RHC_MODE_HIGH;
      rd_chk(RHC_ADDR_FRT_HI, 8'h00, "timer after standby");
      end_of_test();
   end

   // the sequence needs about three hundred and thirty cycles
   initial
   begin
      repeat (20000) @(posedge mclk);
      err_total++;
      end_of_test();
   end
endmodule
